// ==== rtl/pbc_pkg.sv ====
package pbc_pkg;

  localparam logic [4:0] CTRL_ADDR = 5'h00;

  localparam int BIT_RST = 15;
  localparam int BIT_LOOPBACK_ENABLE = 14;
  localparam int BIT_SPD_LSB = 13;
  localparam int BIT_AUTONEG_ENABLE = 12;
  localparam int BIT_PDN = 11;
  localparam int BIT_ISO = 10;
  localparam int BIT_RESTART = 9;
  localparam int BIT_DUPLEX_SELECT = 8;
  localparam int BIT_COLLISION_TEST = 7;

  localparam logic RST_SPD_LSB = 1'h1;
  localparam logic RST_AUTONEG_ENABLE = 1'h1;
  localparam logic RST_DUPLEX_SELECT = 1'h1;

  localparam int CLK_MHZ = 250;
  localparam int SRST_US = 25;
  localparam int SRST_CYC = SRST_US * CLK_MHZ;
  localparam int SRST_CW = 13;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbc_mgmt_req_t;

  typedef struct packed {
    logic [3:0] txd;
    logic txen;
    logic txer;
  } pbc_mii_tx_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic crs_dv;
    logic rx_er;
    logic col;
    logic crs;
  } pbc_mii_rx_t;

  typedef struct packed {
    logic line_tx_positive;
    logic line_tx_negative;
  } pbc_line_tx_t;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } pbc_an_res_t;

  typedef struct packed {
    logic init_pend;
    logic fiber;
    logic srst;
    logic [SRST_CW-1:0] srst_cnt;
    logic loopback_enable;
    logic spd_lsb;
    logic autoneg_enable;
    logic power_down_bit;
    logic isolate;
    logic autoneg_restart;
    logic duplex_select;
    logic collision_test;
    logic rvalid;
    logic [15:0] rdata;
    logic speed_100;
    logic full_duplex;
    logic power_down;
    logic line_oe_n;
    logic led_oe_n;
    logic mii_oe_n;
    pbc_line_tx_t line_tx;
    pbc_mii_tx_t phy_tx;
    pbc_mii_rx_t mii_rx;
  } pbc_state_t;

endpackage

// ==== rtl/pbc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl
#(
  parameter int P_SRST_CYC = pbc_pkg::SRST_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire pbc_pkg::pbc_mgmt_req_t i_mgmt,
  input wire logic i_fiber_mode,
  input wire logic i_autoneg_strap_pin,
  input wire logic i_power_down_pin,
  input wire logic i_an_ack,
  input wire pbc_pkg::pbc_an_res_t i_an_res,
  input wire pbc_pkg::pbc_mii_tx_t i_mii_tx,
  input wire pbc_pkg::pbc_mii_rx_t i_phy_rx,
  input wire pbc_pkg::pbc_line_tx_t i_line_tx_core,
  output logic o_mgmt_rvalid,
  output logic [15:0] o_mgmt_rdata,
  output logic o_port_rst,
  output logic o_autoneg_restart,
  output logic o_autoneg_on,
  output logic o_speed_100,
  output logic o_full_duplex,
  output logic o_power_down,
  output pbc_pkg::pbc_line_tx_t o_line_tx,
  output logic o_line_oe_n,
  output logic o_led_oe_n,
  output pbc_pkg::pbc_mii_tx_t o_phy_tx,
  output pbc_pkg::pbc_mii_rx_t o_mii_rx,
  output logic o_mii_oe_n
);
  import pbc_pkg::*;

  pbc_state_t s_q;
  pbc_state_t s_d;
  logic wr0;
  logic pd;
  logic iso;
  logic autoneg_enable_new;
  logic [15:0] ctrl_word;

  always_comb
  begin
    ctrl_word = 16'h0000;
    ctrl_word[BIT_RST] = s_q.srst;
    ctrl_word[BIT_LOOPBACK_ENABLE] = s_q.loopback_enable;
    ctrl_word[BIT_SPD_LSB] = s_q.spd_lsb | s_q.fiber;
    ctrl_word[BIT_AUTONEG_ENABLE] = s_q.autoneg_enable;
    ctrl_word[BIT_PDN] = s_q.power_down_bit;
    ctrl_word[BIT_ISO] = s_q.isolate;
    ctrl_word[BIT_RESTART] = s_q.autoneg_restart;
    ctrl_word[BIT_DUPLEX_SELECT] = s_q.duplex_select;
    ctrl_word[BIT_COLLISION_TEST] = s_q.collision_test;
  end

  always_comb
  begin
    s_d = s_q;
    wr0 = i_mgmt.wr && (i_mgmt.addr == CTRL_ADDR);
    pd = s_q.power_down_bit | i_power_down_pin;
    iso = s_q.isolate | pd;
    autoneg_enable_new = s_q.fiber ? s_q.autoneg_enable : i_mgmt.wdata[BIT_AUTONEG_ENABLE];
    s_d.rvalid = i_mgmt.rd;
    s_d.rdata = (i_mgmt.rd && (i_mgmt.addr == CTRL_ADDR)) ? ctrl_word : 16'h0000;
    if (i_an_ack)
    begin
      s_d.autoneg_restart = 1'b0;
    end
    if (s_q.init_pend)
    begin
      s_d.init_pend = 1'b0;
      s_d.fiber = i_fiber_mode;
      s_d.autoneg_enable = i_autoneg_strap_pin & ~i_fiber_mode;
      s_d.spd_lsb = RST_SPD_LSB;
      // strap-load cycle already counts as the first soft reset cycle
      if (s_q.srst)
      begin
        s_d.srst_cnt = s_q.srst_cnt - SRST_CW'(1);
      end
    end
    else if (s_q.srst)
    begin
      if (s_q.srst_cnt == '0)
      begin
        s_d.srst = 1'b0;
      end
      else
      begin
        s_d.srst_cnt = s_q.srst_cnt - SRST_CW'(1);
      end
    end
    else if (wr0)
    begin
      if (i_mgmt.wdata[BIT_RST])
      begin
        s_d.srst = 1'b1;
        s_d.srst_cnt = SRST_CW'(P_SRST_CYC - 1);
        s_d.init_pend = 1'b1;
        s_d.loopback_enable = 1'b0;
        s_d.power_down_bit = 1'b0;
        s_d.isolate = 1'b0;
        s_d.autoneg_restart = 1'b0;
        s_d.duplex_select = RST_DUPLEX_SELECT;
        s_d.collision_test = 1'b0;
        s_d.autoneg_enable = RST_AUTONEG_ENABLE;
      end
      else
      begin
        s_d.loopback_enable = i_mgmt.wdata[BIT_LOOPBACK_ENABLE];
        s_d.power_down_bit = i_mgmt.wdata[BIT_PDN];
        s_d.isolate = i_mgmt.wdata[BIT_ISO];
        s_d.duplex_select = i_mgmt.wdata[BIT_DUPLEX_SELECT];
        s_d.collision_test = i_mgmt.wdata[BIT_COLLISION_TEST];
        if (!s_q.fiber)
        begin
          s_d.spd_lsb = i_mgmt.wdata[BIT_SPD_LSB];
        end
        s_d.autoneg_enable = autoneg_enable_new;
        if (i_mgmt.wdata[BIT_RESTART] && autoneg_enable_new)
        begin
          s_d.autoneg_restart = 1'b1;
        end
      end
    end
    s_d.speed_100 = s_q.autoneg_enable ? i_an_res.speed_100 : s_q.spd_lsb;
    s_d.full_duplex = s_q.autoneg_enable ? i_an_res.full_duplex : s_q.duplex_select;
    s_d.power_down = pd;
    s_d.line_oe_n = pd | s_q.loopback_enable | s_q.srst;
    s_d.line_tx = i_line_tx_core;
    s_d.led_oe_n = pd;
    s_d.mii_oe_n = iso;
    s_d.phy_tx = (iso | s_q.loopback_enable) ? '0 : i_mii_tx;
    if (iso)
    begin
      s_d.mii_rx = '0;
    end
    else if (s_q.loopback_enable)
    begin
      s_d.mii_rx.rxd = i_mii_tx.txd;
      s_d.mii_rx.crs_dv = i_mii_tx.txen;
      s_d.mii_rx.rx_er = i_mii_tx.txer;
      s_d.mii_rx.crs = i_mii_tx.txen;
      s_d.mii_rx.col = s_q.collision_test & i_mii_tx.txen;
    end
    else
    begin
      s_d.mii_rx = i_phy_rx;
      s_d.mii_rx.col = i_phy_rx.col | (s_q.collision_test & i_mii_tx.txen);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_q <= '0;
      s_q.init_pend <= 1'b1;
      s_q.spd_lsb <= RST_SPD_LSB;
      s_q.autoneg_enable <= RST_AUTONEG_ENABLE;
      s_q.duplex_select <= RST_DUPLEX_SELECT;
      s_q.line_oe_n <= 1'b1;
      s_q.led_oe_n <= 1'b1;
      s_q.mii_oe_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_mgmt_rvalid = s_q.rvalid;
  assign o_mgmt_rdata = s_q.rdata;
  assign o_port_rst = s_q.srst;
  assign o_autoneg_restart = s_q.autoneg_restart;
  assign o_autoneg_on = s_q.autoneg_enable;
  assign o_speed_100 = s_q.speed_100;
  assign o_full_duplex = s_q.full_duplex;
  assign o_power_down = s_q.power_down;
  assign o_line_tx = s_q.line_tx;
  assign o_line_oe_n = s_q.line_oe_n;
  assign o_led_oe_n = s_q.led_oe_n;
  assign o_phy_tx = s_q.phy_tx;
  assign o_mii_rx = s_q.mii_rx;
  assign o_mii_oe_n = s_q.mii_oe_n;

  // cycles spent in soft reset, for checking only
  logic [SRST_CW-1:0] a_len;
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      a_len <= '0;
    end
    else
    begin
      a_len <= s_q.srst ? a_len + SRST_CW'(1) : '0;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_ctrl_rd;
    i_mgmt.rd && (i_mgmt.addr == CTRL_ADDR);
  endsequence

  sequence s_restart_wr;
    wr0 && !s_q.init_pend && !s_q.srst && !i_mgmt.wdata[BIT_RST]
      && i_mgmt.wdata[BIT_RESTART] && i_mgmt.wdata[BIT_AUTONEG_ENABLE] && !s_q.fiber;
  endsequence

  // reset bit never high longer than the full time
  a_srst_bound: assert property (s_q.srst |-> a_len < SRST_CW'(P_SRST_CYC))
    else $error("soft reset lasts too long");
  // reset bit clears after exact time
  a_srst_length: assert property ($fell(s_q.srst) |-> $past(a_len) == SRST_CW'(P_SRST_CYC - 1))
    else $error("soft reset ended early");
  a_srst_start: assert property (wr0 && i_mgmt.wdata[BIT_RST] && !s_q.init_pend && !s_q.srst
    |=> o_port_rst ##1 s_q.init_pend == 1'b0)
    else $error("soft reset did not start");
  // reset bit reads one during reset
  a_srst_read: assert property (s_ctrl_rd |=> o_mgmt_rvalid && o_mgmt_rdata[BIT_RST] == $past(s_q.srst))
    else $error("reset bit readback wrong");
  a_strap_load: assert property ($fell(s_q.init_pend)
    |-> s_q.autoneg_enable == ($past(i_autoneg_strap_pin) && !$past(i_fiber_mode)))
    else $error("strap not loaded");
  a_fixed_zero: assert property (o_mgmt_rvalid |-> o_mgmt_rdata[6:0] == 7'h00)
    else $error("reserved bits not zero");
  a_fiber_lsb: assert property (s_ctrl_rd ##0 s_q.fiber |=> o_mgmt_rdata[BIT_SPD_LSB])
    else $error("fiber speed bit not one");
  a_fiber_autoneg_enable: assert property (s_q.fiber && !s_q.init_pend |-> !s_q.autoneg_enable)
    else $error("autoneg set in fiber");
  a_pd_or: assert property ((s_q.power_down_bit || i_power_down_pin)
    |=> o_power_down && o_line_oe_n && o_led_oe_n && o_mii_oe_n)
    else $error("power-down not applied");
  a_iso_block: assert property (s_q.isolate |=> o_mii_oe_n && o_phy_tx == '0)
    else $error("isolate not applied");
  a_loop_route: assert property (s_q.loopback_enable && !s_q.isolate && !pd
    |=> o_line_oe_n && o_mii_rx.rxd == $past(i_mii_tx.txd) && o_mii_rx.crs_dv == $past(i_mii_tx.txen))
    else $error("loopback path wrong");
  a_col_test: assert property (s_q.collision_test && i_mii_tx.txen && !iso |=> o_mii_rx.col)
    else $error("collision test missing");
  a_forced_mode: assert property (!s_q.autoneg_enable
    |=> o_speed_100 == $past(s_q.spd_lsb) && o_full_duplex == $past(s_q.duplex_select))
    else $error("forced mode wrong");
  // restart set, then cleared by ack
  a_restart_set: assert property (s_restart_wr |=> o_autoneg_restart)
    else $error("restart not set");
  a_restart_clr: assert property (s_q.autoneg_restart && i_an_ack && !(s_restart_wr) |=> !o_autoneg_restart)
    else $error("restart not cleared");

endmodule
`default_nettype wire

// ==== testbench/pbc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbc_host_model
(
  input wire logic i_mclk,
  output pbc_pkg::pbc_mgmt_req_t o_mgmt
);
  import pbc_pkg::*;
  initial o_mgmt = '0;
  // one-cycle strobe; idle fields show inverted values, never the old ones
  task automatic put(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    o_mgmt <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_mclk);
    o_mgmt <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// ==== testbench/phy_basic_control_register_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_register_test;
  import pbc_pkg::*;
  localparam int SC = 8;
  logic mclk, rstn, fib, strap, pdp, ack, rv, prst, arst, aon, s100, fdx, pd, loe, led, moe;
  logic [15:0] rdat;
  logic [31:0] seed = 32'h0001_386B;
  logic [31:0] r;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  pbc_mgmt_req_t mg;
  pbc_an_res_t anr;
  pbc_mii_tx_t mtx, ptx;
  pbc_mii_rx_t prx, mrx;
  pbc_line_tx_t lcore, ltx;

  pbc_host_model u_host (.i_mclk(mclk), .o_mgmt(mg));

  pbc_ctrl #(.P_SRST_CYC(SC)) u_dut (.i_mclk(mclk), .i_rstn(rstn), .i_mgmt(mg), .i_fiber_mode(fib),
    .i_autoneg_strap_pin(strap), .i_power_down_pin(pdp), .i_an_ack(ack), .i_an_res(anr),
    .i_mii_tx(mtx), .i_phy_rx(prx), .i_line_tx_core(lcore), .o_mgmt_rvalid(rv), .o_mgmt_rdata(rdat),
    .o_port_rst(prst), .o_autoneg_restart(arst), .o_autoneg_on(aon), .o_speed_100(s100),
    .o_full_duplex(fdx), .o_power_down(pd), .o_line_tx(ltx), .o_line_oe_n(loe), .o_led_oe_n(led),
    .o_phy_tx(ptx), .o_mii_rx(mrx), .o_mii_oe_n(moe));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [15:0] d);
    u_host.put(1'b1, 5'h00, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.put(1'b0, a, 16'h0000);
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  always @(negedge mclk)
    if (rv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(rdat, 16'hFFFF);
      else
        chk(rdat, exp_q.pop_front());
    end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  initial
  begin
    rstn = 1'b0;
    {fib, pdp, ack} = 3'h0;
    strap = 1'b1;
    anr = '0;
    mtx = '0;
    prx = '0;
    lcore = '0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(5'h00, 16'h3100);
    rd(5'h01, 16'h0000);
    wr(16'h21FF);
    rd(5'h00, 16'h2180);
    settle();
    chk({s100, fdx}, 2'h3);
    wr(16'h0000);
    settle();
    chk({s100, fdx}, 2'h0);
    wr(16'h4000);
    r = xs();
    mtx <= '{txd: r[3:0], txen: 1'b1, txer: r[4]};
    prx <= r[12:5];
    lcore <= r[14:13];
    settle();
    chk(mrx.rxd, r[3:0]);
    chk({mrx.crs_dv, mrx.rx_er, loe}, {1'b1, r[4], 1'b1});
    chk(ltx, r[14:13]);
    wr(16'h0080);
    prx <= '0;
    settle();
    chk(mrx.col, 1'b1);
    chk(ptx, {r[3:0], 1'b1, r[4]});
    wr(16'h0400);
    mtx <= '1;
    settle();
    chk({moe, ptx, mrx}, 15'h4000);
    rd(5'h00, 16'h0400);
    for (int i = 0; i < 2; i++)
    begin
      wr(i ? 16'h0800 : 16'h0000);
      pdp <= !i;
      settle();
      chk(pd, 1'b1);
      chk({led, loe, moe}, 3'h7);
    end
    wr(16'h3200);
    pdp <= 1'b0;
    settle();
    chk({arst, aon, s100, fdx}, 4'hC);
    @(posedge mclk);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    settle();
    chk(arst, 1'b0);
    rd(5'h00, 16'h3000);
    strap <= 1'b0;
    wr(16'h8000);
    repeat (3) @(posedge mclk);
    rd(5'h00, 16'hA100);
    @(negedge mclk);
    chk(prst, 1'b1);
    repeat (12) @(posedge mclk);
    rd(5'h00, 16'h2100);
    fib <= 1'b1;
    wr(16'h8000);
    repeat (14) @(posedge mclk);
    rd(5'h00, 16'h2100);
    wr(16'h1000);
    rd(5'h00, 16'h2000);
    settle();
    finish_test();
  end
endmodule
`default_nettype wire
